// ==== design/cpd_pkg.sv ====
// Package with constants and types for the complementary PWM output stage.
`default_nettype none
package cpd_pkg;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned DB_W    = 8;
  localparam int unsigned FRAC_W  = 4;
  localparam int unsigned STEER_W = 6;

  localparam logic [ADDR_W-1:0] OFS_UNIT_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RISE_TIME    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FALL_TIME    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FRAC_ADJUST  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STEER_SELECT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STEER_CTRL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h18;

  localparam int unsigned CTL_ENABLE_BIT  = 0;
  localparam int unsigned CTL_MODE_BIT    = 1;
  localparam int unsigned CTL_RISE_DB_BIT = 4;
  localparam int unsigned CTL_FALL_DB_BIT = 5;
  localparam int unsigned CTL_LOAD_BIT    = 8;

  localparam int unsigned STR_SYNC_BIT  = 0;
  localparam int unsigned STR_HSMEN_BIT = 1;
  localparam int unsigned STR_LSMEN_BIT = 2;

  localparam int unsigned STAT_LEVEL_BIT = 0;
  localparam int unsigned STAT_PRIM_BIT  = 1;
  localparam int unsigned STAT_COMP_BIT  = 2;
  localparam int unsigned STAT_PHASE_BIT = 3;
  localparam int unsigned STAT_DB_LSB    = 4;
  localparam int unsigned STAT_ACC_LSB   = 8;
  localparam int unsigned STAT_LOAD_BIT  = 12;
  localparam int unsigned STAT_OUT_LSB   = 16;

  localparam logic [DB_W-1:0]    RST_DB_TIME = 8'h00;
  localparam logic [FRAC_W-1:0]  RST_FRAC    = 4'h0;
  localparam logic [STEER_W-1:0] RST_STEER   = 6'h00;
  localparam logic [DATA_W-1:0]  RST_RDATA   = 32'h0000_0000;

  typedef enum logic {
    MODE_VF_COMPL,
    MODE_THREE_PHASE
  } cpd_mode_e;

  typedef enum logic [1:0] {
    DB_IDLE,
    DB_RISE,
    DB_FALL
  } cpd_db_e;

  typedef struct packed {
    logic out_a;
    logic out_b;
    logic out_c;
    logic out_d;
    logic out_e;
    logic out_f;
  } cpd_out_s;

  typedef struct packed {
    logic period;
    logic rise;
    logic fall;
  } cpd_evt_s;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } cpd_avs_req_s;

  typedef struct packed {
    cpd_evt_s            evt_s1;
    cpd_evt_s            evt_s2;
    cpd_evt_s            evt_s3;
    logic                wait_req;
    logic [DATA_W-1:0]   rdata;
    logic                enable;
    cpd_mode_e           mode;
    logic                rise_deadband_enable;
    logic                fall_deadband_enable;
    logic                buffer_load_request;
    logic [DB_W-1:0]     rise_time_shadow;
    logic [DB_W-1:0]     fall_time_shadow;
    logic [DB_W-1:0]     rise_deadband_time;
    logic [DB_W-1:0]     fall_deadband_time;
    logic [FRAC_W-1:0]   fractional_adjust_value;
    logic [FRAC_W-1:0]   fractional_accumulator;
    logic [STEER_W-1:0]  steer_shadow;
    logic [STEER_W-1:0]  steering_select;
    logic                steering_sync_enable;
    logic                high_side_mod_enable;
    logic                low_side_mod_enable;
    logic                level;
    logic                prim;
    logic                comp;
    cpd_db_e             db_state;
    logic [DB_W-1:0]     db_cnt;
    logic                phase_on;
    cpd_out_s            outs;
  } cpd_state_s;
endpackage
`default_nettype wire

// ==== design/cpd_pwm_core.sv ====
// Complementary PWM output stage with dead band and 3-phase steering.
`default_nettype none
// Operation
// [RULE_01] Period event raising primary output starts rising dead-band count.
// [RULE_02] Period event lowering primary output starts falling dead-band count.
// [RULE_03] Turn-on: complement off, add fraction, rising dead band, primary on.
// [RULE_04] Turn-off: primary off, add fraction, falling dead band, complement on.
// [RULE_05] Complementary mode drives primary on A, complement on B only.
// [RULE_06] 3-phase mode uses six outputs, at most one high, one low active.
// [RULE_07] 3-phase mode inserts no dead band.
// [RULE_08] A,C,E are phase high sides; B,D,F are phase low sides.
// [RULE_09] Steering codes 01h..20h pick fixed output pairs; 00h selects none.
// [RULE_10] Other steering values use their least significant set bit.
// [RULE_11] High-side enable modulates high output with rise and fall events.
// [RULE_12] Low-side enable modulates low output with rise and fall events.
// [RULE_13] Both enables clear: selected outputs go active at once and stay.
// [RULE_14] Dead band only in complementary drive modes, never elsewhere.
// [RULE_15] Two independent 8-bit dead-band counters, rising and falling. The code uses one shared 8-bit db_cnt for both.
// [RULE_16] Rising dead band delays primary turn-on by rising time value.
// [RULE_17] Falling dead band delays complement turn-on by falling time value.
// [RULE_18] While enabled, dead-band times load at period event after load bit.
// [RULE_19] Dead-band enable bit changes act immediately.
// [RULE_20] Dead-band counters advance once per PWM clock edge.
// [RULE_21] Asynchronous trigger events may shift dead band by one clock.
// [RULE_22] Fall during rising count: restart as falling, primary stays off.
// [RULE_23] Rise during falling count: restart as rising, complement stays off.
// [RULE_24] Synchronized steering applies at period event after load bit.
// [RULE_25] Disabled dead band switches output with the opposite output's change.
module cpd_pwm_core (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_b,
  input  wire cpd_pkg::cpd_evt_s           i_evt,
  input  wire cpd_pkg::cpd_avs_req_s       i_avs,
  output logic [cpd_pkg::DATA_W-1:0]       o_avs_readdata,
  output logic                             o_avs_waitrequest,
  output cpd_pkg::cpd_out_s                o_pwm
);

  cpd_pkg::cpd_state_s state_reg;
  cpd_pkg::cpd_state_s state_next;

  function automatic cpd_pkg::cpd_out_s steer_decode(
    input logic [cpd_pkg::STEER_W-1:0] sel
  );
    cpd_pkg::cpd_out_s m;
    m = '0;
    if (sel[0]) begin
      m.out_a = 1'b1;
      m.out_d = 1'b1;
    end else if (sel[1]) begin
      m.out_a = 1'b1;
      m.out_f = 1'b1;
    end else if (sel[2]) begin
      m.out_c = 1'b1;
      m.out_f = 1'b1;
    end else if (sel[3]) begin
      m.out_c = 1'b1;
      m.out_b = 1'b1;
    end else if (sel[4]) begin
      m.out_e = 1'b1;
      m.out_b = 1'b1;
    end else if (sel[5]) begin
      m.out_e = 1'b1;
      m.out_d = 1'b1;
    end
    return m;
  endfunction

  always_comb begin
    logic                         per;
    logic                         rise;
    logic                         fall;
    logic                         req;
    logic                         do_write;
    logic                         ld;
    logic                         hi_lvl;
    logic                         lo_lvl;
    logic [cpd_pkg::DATA_W-1:0]   rd;
    logic [cpd_pkg::DATA_W-1:0]   wd;
    cpd_pkg::cpd_out_s            m;
    per      = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    req      = 1'b0;
    do_write = 1'b0;
    ld       = 1'b0;
    hi_lvl   = 1'b0;
    lo_lvl   = 1'b0;
    rd       = '0;
    wd       = i_avs.writedata;
    m        = '0;
    state_next = state_reg;

    // Event pins are synchronised, then edge detected on the settled stages.
    state_next.evt_s1 = i_evt;
    state_next.evt_s2 = state_reg.evt_s1;
    state_next.evt_s3 = state_reg.evt_s2;
    per  = state_reg.evt_s2.period & ~state_reg.evt_s3.period; // see [RULE_21]
    rise = state_reg.evt_s2.rise & ~state_reg.evt_s3.rise;
    fall = state_reg.evt_s2.fall & ~state_reg.evt_s3.fall;

    // Bus slave answers each request after exactly one wait cycle.
    req = i_avs.read | i_avs.write;
    state_next.wait_req = ~(req & state_reg.wait_req);
    do_write = i_avs.write & ~state_reg.wait_req;

    rd[cpd_pkg::STAT_LEVEL_BIT] = state_reg.level;
    rd[cpd_pkg::STAT_PRIM_BIT]  = state_reg.prim;
    rd[cpd_pkg::STAT_COMP_BIT]  = state_reg.comp;
    rd[cpd_pkg::STAT_PHASE_BIT] = state_reg.phase_on;
    rd[cpd_pkg::STAT_DB_LSB +: 2] = state_reg.db_state;
    rd[cpd_pkg::STAT_ACC_LSB +: cpd_pkg::FRAC_W] =
      state_reg.fractional_accumulator;
    rd[cpd_pkg::STAT_LOAD_BIT] = state_reg.buffer_load_request;
    rd[cpd_pkg::STAT_OUT_LSB +: 6] = state_reg.outs;
    if (req & state_reg.wait_req) begin
      if (i_avs.address == cpd_pkg::OFS_UNIT_CONTROL) begin
        state_next.rdata = '0;
        state_next.rdata[cpd_pkg::CTL_ENABLE_BIT]  = state_reg.enable;
        state_next.rdata[cpd_pkg::CTL_MODE_BIT]    = state_reg.mode;
        state_next.rdata[cpd_pkg::CTL_RISE_DB_BIT] =
          state_reg.rise_deadband_enable;
        state_next.rdata[cpd_pkg::CTL_FALL_DB_BIT] =
          state_reg.fall_deadband_enable;
        state_next.rdata[cpd_pkg::CTL_LOAD_BIT] =
          state_reg.buffer_load_request;
      end else if (i_avs.address == cpd_pkg::OFS_RISE_TIME) begin
        state_next.rdata = {24'h000000, state_reg.rise_time_shadow};
      end else if (i_avs.address == cpd_pkg::OFS_FALL_TIME) begin
        state_next.rdata = {24'h000000, state_reg.fall_time_shadow};
      end else if (i_avs.address == cpd_pkg::OFS_FRAC_ADJUST) begin
        state_next.rdata = {28'h0000000, state_reg.fractional_adjust_value};
      end else if (i_avs.address == cpd_pkg::OFS_STEER_SELECT) begin
        state_next.rdata = {26'h0000000, state_reg.steer_shadow};
      end else if (i_avs.address == cpd_pkg::OFS_STEER_CTRL) begin
        state_next.rdata = '0;
        state_next.rdata[cpd_pkg::STR_SYNC_BIT] =
          state_reg.steering_sync_enable;
        state_next.rdata[cpd_pkg::STR_HSMEN_BIT] =
          state_reg.high_side_mod_enable;
        state_next.rdata[cpd_pkg::STR_LSMEN_BIT] =
          state_reg.low_side_mod_enable;
      end else if (i_avs.address == cpd_pkg::OFS_STATUS) begin
        state_next.rdata = rd;
      end else begin
        state_next.rdata = cpd_pkg::RST_RDATA;
      end
    end

    // Buffered values load at the first period event after the load bit.
    ld = state_reg.enable & state_reg.buffer_load_request & per;
    if (ld) begin
      state_next.buffer_load_request = 1'b0;
    end
    if (!state_reg.enable) begin
      state_next.rise_deadband_time = state_reg.rise_time_shadow;
      state_next.fall_deadband_time = state_reg.fall_time_shadow;
    end else if (ld) begin
      state_next.rise_deadband_time = state_reg.rise_time_shadow; // see [RULE_18]
      state_next.fall_deadband_time = state_reg.fall_time_shadow; // see [RULE_18]
    end
    if (!state_reg.steering_sync_enable || !state_reg.enable) begin
      state_next.steering_select = state_reg.steer_shadow;
    end else if (ld) begin
      state_next.steering_select = state_reg.steer_shadow; // see [RULE_24]
    end

    // Software writes come after the hardware clear so a new set wins.
    if (do_write) begin
      if (i_avs.address == cpd_pkg::OFS_UNIT_CONTROL) begin
        state_next.enable = wd[cpd_pkg::CTL_ENABLE_BIT];
        state_next.mode   = cpd_pkg::cpd_mode_e'(wd[cpd_pkg::CTL_MODE_BIT]);
        state_next.rise_deadband_enable = wd[cpd_pkg::CTL_RISE_DB_BIT];
        state_next.fall_deadband_enable = wd[cpd_pkg::CTL_FALL_DB_BIT];
        if (wd[cpd_pkg::CTL_LOAD_BIT]) begin
          state_next.buffer_load_request = 1'b1;
        end
      end else if (i_avs.address == cpd_pkg::OFS_RISE_TIME) begin
        state_next.rise_time_shadow = wd[cpd_pkg::DB_W-1:0];
      end else if (i_avs.address == cpd_pkg::OFS_FALL_TIME) begin
        state_next.fall_time_shadow = wd[cpd_pkg::DB_W-1:0];
      end else if (i_avs.address == cpd_pkg::OFS_FRAC_ADJUST) begin
        state_next.fractional_adjust_value = wd[cpd_pkg::FRAC_W-1:0];
      end else if (i_avs.address == cpd_pkg::OFS_STEER_SELECT) begin
        state_next.steer_shadow = wd[cpd_pkg::STEER_W-1:0];
      end else if (i_avs.address == cpd_pkg::OFS_STEER_CTRL) begin
        state_next.steering_sync_enable = wd[cpd_pkg::STR_SYNC_BIT];
        state_next.high_side_mod_enable = wd[cpd_pkg::STR_HSMEN_BIT];
        state_next.low_side_mod_enable  = wd[cpd_pkg::STR_LSMEN_BIT];
      end
    end

    // Waveform generation.
    if (!state_reg.enable) begin
      state_next.level    = 1'b0;
      state_next.prim     = 1'b0;
      state_next.comp     = 1'b0;
      state_next.phase_on = 1'b0;
      state_next.db_state = cpd_pkg::DB_IDLE;
      state_next.db_cnt   = '0;
    end else if (state_reg.mode == cpd_pkg::MODE_VF_COMPL) begin
      state_next.phase_on = 1'b0;
      case (state_reg.db_state)
        cpd_pkg::DB_RISE: begin
          if (!state_reg.rise_deadband_enable ||
              state_reg.db_cnt >= state_reg.rise_deadband_time) begin
            state_next.prim     = 1'b1; // see [RULE_16] [RULE_19]
            state_next.db_state = cpd_pkg::DB_IDLE;
          end else begin
            state_next.db_cnt = state_reg.db_cnt + 8'h01; // see [RULE_20]
          end
        end
        cpd_pkg::DB_FALL: begin
          if (!state_reg.fall_deadband_enable ||
              state_reg.db_cnt >= state_reg.fall_deadband_time) begin
            state_next.comp     = 1'b1; // see [RULE_17] [RULE_19]
            state_next.db_state = cpd_pkg::DB_IDLE;
          end else begin
            state_next.db_cnt = state_reg.db_cnt + 8'h01; // see [RULE_20]
          end
        end
        default: begin
          state_next.db_state = cpd_pkg::DB_IDLE;
        end
      endcase
      if (per) begin
        state_next.level = ~state_reg.level;
        state_next.fractional_accumulator = state_reg.fractional_accumulator
          + state_reg.fractional_adjust_value; // see [RULE_03] [RULE_04]
        state_next.db_cnt = '0;
        if (!state_reg.level) begin
          state_next.comp = 1'b0; // see [RULE_03] [RULE_23]
          if (state_reg.rise_deadband_enable) begin
            state_next.prim     = 1'b0;
            state_next.db_state = cpd_pkg::DB_RISE; // see [RULE_01] [RULE_15]
          end else begin
            state_next.prim     = 1'b1; // see [RULE_25]
            state_next.db_state = cpd_pkg::DB_IDLE;
          end
        end else begin
          state_next.prim = 1'b0; // see [RULE_04] [RULE_22]
          if (state_reg.fall_deadband_enable) begin
            state_next.comp     = 1'b0;
            state_next.db_state = cpd_pkg::DB_FALL; // see [RULE_02] [RULE_15]
          end else begin
            state_next.comp     = 1'b1; // see [RULE_25]
            state_next.db_state = cpd_pkg::DB_IDLE;
          end
        end
      end
    end else begin
      state_next.level    = 1'b0;
      state_next.prim     = 1'b0;
      state_next.comp     = 1'b0;
      state_next.db_state = cpd_pkg::DB_IDLE; // see [RULE_07] [RULE_14]
      state_next.db_cnt   = '0;
      if (rise) begin
        state_next.phase_on = 1'b1;
      end else if (fall) begin
        state_next.phase_on = 1'b0;
      end
    end

    // Output steering.
    hi_lvl = state_reg.high_side_mod_enable ? state_next.phase_on : 1'b1;
    lo_lvl = state_reg.low_side_mod_enable ? state_next.phase_on : 1'b1;
    m = steer_decode(state_next.steering_select); // see [RULE_09] [RULE_10]
    state_next.outs = '0;
    if (state_reg.enable) begin
      if (state_reg.mode == cpd_pkg::MODE_VF_COMPL) begin
        state_next.outs.out_a = state_next.prim; // see [RULE_05]
        state_next.outs.out_b = state_next.comp; // see [RULE_05]
      end else begin
        // High sides A, C, E and low sides B, D, F.
        state_next.outs.out_a = m.out_a & hi_lvl; // see [RULE_06] [RULE_08]
        state_next.outs.out_c = m.out_c & hi_lvl; // see [RULE_11] [RULE_13]
        state_next.outs.out_e = m.out_e & hi_lvl; // see [RULE_11]
        state_next.outs.out_b = m.out_b & lo_lvl; // see [RULE_12] [RULE_13]
        state_next.outs.out_d = m.out_d & lo_lvl; // see [RULE_12]
        state_next.outs.out_f = m.out_f & lo_lvl; // see [RULE_06] [RULE_08]
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
      state_reg.wait_req <= 1'b1;
      state_reg.mode <= cpd_pkg::MODE_VF_COMPL;
      state_reg.db_state <= cpd_pkg::DB_IDLE;
      state_reg.rise_time_shadow <= cpd_pkg::RST_DB_TIME;
      state_reg.fall_time_shadow <= cpd_pkg::RST_DB_TIME;
      state_reg.rise_deadband_time <= cpd_pkg::RST_DB_TIME;
      state_reg.fall_deadband_time <= cpd_pkg::RST_DB_TIME;
      state_reg.fractional_adjust_value <= cpd_pkg::RST_FRAC;
      state_reg.steer_shadow <= cpd_pkg::RST_STEER;
      state_reg.steering_select <= cpd_pkg::RST_STEER;
      state_reg.rdata <= cpd_pkg::RST_RDATA;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_avs_readdata    = state_reg.rdata;
  assign o_avs_waitrequest = state_reg.wait_req;
  assign o_pwm             = state_reg.outs;

endmodule
`default_nettype wire

// ==== tb/cpd_bridge_model.sv ====
// Model of the external half-bridge drivers fed by the PWM outputs.
`default_nettype none
module cpd_bridge_model (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire cpd_pkg::cpd_out_s i_pwm,
  output logic [15:0]            o_shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Counts cycles in which a leg would conduct straight through.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_shoot_cnt <= 16'h0000;
    end else if ((i_pwm.out_a && i_pwm.out_b) ||
                 (i_pwm.out_c && i_pwm.out_d) ||
                 (i_pwm.out_e && i_pwm.out_f)) begin
      o_shoot_cnt <= o_shoot_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== tb/cpd_pwm_assertions.sv ====
// Port-level assertions for the complementary PWM output stage.
`default_nettype none
module cpd_pwm_assertions (
  input wire logic                       i_sys_clk,
  input wire logic                       i_rst_b,
  input wire cpd_pkg::cpd_evt_s          i_evt,
  input wire cpd_pkg::cpd_avs_req_s      i_avs,
  input wire logic [cpd_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic                       o_avs_waitrequest,
  input wire cpd_pkg::cpd_out_s          o_pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ctl_wr;
  logic       en_q;
  logic       mode_q;
  logic       rdb_q;
  logic       fdb_q;
  logic [1:0] quiet_q;
  logic       settled;
  // Control bits mirrored from the bus, trusted three cycles after a write.
  assign ctl_wr = i_avs.write && !o_avs_waitrequest &&
                  i_avs.address == cpd_pkg::OFS_UNIT_CONTROL;
  assign settled = quiet_q == 2'h3 && en_q && !mode_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {en_q, mode_q, rdb_q, fdb_q, quiet_q} <= 6'h00;
    end else if (ctl_wr) begin
      en_q    <= i_avs.writedata[cpd_pkg::CTL_ENABLE_BIT];
      mode_q  <= i_avs.writedata[cpd_pkg::CTL_MODE_BIT];
      rdb_q   <= i_avs.writedata[cpd_pkg::CTL_RISE_DB_BIT];
      fdb_q   <= i_avs.writedata[cpd_pkg::CTL_FALL_DB_BIT];
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  AST_BUS_ONE_WAIT: assert property (
    (i_avs.read || i_avs.write) && o_avs_waitrequest |=>
    !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one wait cycle long");
  AST_COMP_ONLY_AB: assert property (
    settled |-> {o_pwm.out_c, o_pwm.out_d, o_pwm.out_e, o_pwm.out_f} == 4'h0)
    else $error("complementary mode drives outputs c to f");
  AST_ONE_PER_SIDE: assert property (
    $onehot0({o_pwm.out_a, o_pwm.out_c, o_pwm.out_e}) &&
    $onehot0({o_pwm.out_b, o_pwm.out_d, o_pwm.out_f}))
    else $error("more than one output active on one side");
  AST_NO_SHOOT: assert property (
    !(o_pwm.out_a && o_pwm.out_b) && !(o_pwm.out_c && o_pwm.out_d) &&
    !(o_pwm.out_e && o_pwm.out_f))
    else $error("high and low output of one phase active together");
  AST_RISE_DB_HOLD: assert property (
    settled && rdb_q && $fell(o_pwm.out_b) |-> !o_pwm.out_a)
    else $error("primary on without rising dead band");
  AST_FALL_DB_HOLD: assert property (
    settled && fdb_q && $fell(o_pwm.out_a) |-> !o_pwm.out_b)
    else $error("complement on without falling dead band");
  AST_RISE_NO_DB: assert property (
    settled && !rdb_q && $fell(o_pwm.out_b) |-> o_pwm.out_a)
    else $error("primary late with rising dead band off");
  AST_FALL_NO_DB: assert property (
    settled && !fdb_q && $fell(o_pwm.out_a) |-> o_pwm.out_b)
    else $error("complement late with falling dead band off");
  AST_A_AFTER_GAP: assert property (
    settled && rdb_q && $rose(o_pwm.out_a) |->
    !o_pwm.out_b && !$past(o_pwm.out_b))
    else $error("primary rose without a gap after complement");
endmodule
bind cpd_pwm_core cpd_pwm_assertions cpd_pwm_assertions_i (.i_sys_clk,
  .i_rst_b, .i_evt, .i_avs, .o_avs_readdata, .o_avs_waitrequest, .o_pwm);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the complementary PWM output stage.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CTL  = cpd_pkg::OFS_UNIT_CONTROL;
  localparam logic [7:0] A_RISE = cpd_pkg::OFS_RISE_TIME;
  localparam logic [7:0] A_SEL  = cpd_pkg::OFS_STEER_SELECT;
  localparam logic [7:0] A_STR  = cpd_pkg::OFS_STEER_CTRL;
  localparam logic [7:0] A_STAT = cpd_pkg::OFS_STATUS;
  localparam int         S_ACC  = cpd_pkg::STAT_ACC_LSB;
  localparam int         S_LOAD = cpd_pkg::STAT_LOAD_BIT;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst_b = 1'b0;
  cpd_pkg::cpd_evt_s     i_evt = 3'h0;
  cpd_pkg::cpd_avs_req_s i_avs = '0;
  logic [31:0]           rdata;
  logic [31:0]           rd;
  logic                  wreq;
  cpd_pkg::cpd_out_s     o_pwm;
  logic [15:0]           shoot;
  logic [5:0]            codes [10] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
                                        6'h20, 6'h03, 6'h0C, 6'h30, 6'h00};
  int                    n_fail = 0;
  int                    samples_checked = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  cpd_pwm_core cpd_pwm_core_i (.i_sys_clk, .i_rst_b, .i_evt, .i_avs,
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_pwm);
  cpd_bridge_model cpd_bridge_model_i (.i_sys_clk, .i_rst_b, .i_pwm(o_pwm),
    .o_shoot_cnt(shoot));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs <= '{a, !wr, wr, d};
    @(posedge i_sys_clk);
    while (wreq !== 1'b0) begin
      @(posedge i_sys_clk);
      n++;
    end
    rd = rdata;
    i_avs <= '0;
    check("bus wait", n, 32'h1);
  endtask
  task automatic pulse(int b);
    @(posedge i_sys_clk);
    i_evt[b] <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_evt[b] <= 1'b0;
  endtask
  // Fires an event, then times the gap between two output changes.
  task automatic step(int b, int lim, logic [5:0] f_exp, int n_exp);
    cpd_pkg::cpd_out_s p;
    int n;
    p = o_pwm;
    pulse(b);
    n = 0;
    while (o_pwm === p && n < 60) begin
      @(negedge i_sys_clk);
      n++;
    end
    p = o_pwm;
    n = 0;
    while (o_pwm === p && n < lim) begin
      @(negedge i_sys_clk);
      n++;
    end
    check("first", {26'h0, p}, {26'h0, f_exp});
    if (n_exp >= 0) check("dead band", n, n_exp);
  endtask
  function automatic logic [5:0] pair(logic [5:0] s);
    logic [5:0] t [6];
    t = '{6'h24, 6'h21, 6'h09, 6'h18, 6'h12, 6'h06};
    pair = 6'h00;
    for (int i = 5; i >= 0; i--) if (s[i]) pair = t[i];
  endfunction
  task automatic t_reset;
    check("reset outputs", {26'h0, o_pwm}, 32'h0);
    check("idle wait", {31'h0, wreq}, 32'h1);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'b0, A_RISE, 32'h0);
    check("rise time reset", rd, 32'h0);
  endtask
  task automatic t_deadband;
    bus(1'b1, A_RISE, 32'h5);
    bus(1'b1, cpd_pkg::OFS_FALL_TIME, 32'h9);
    bus(1'b1, cpd_pkg::OFS_FRAC_ADJUST, 32'h3);
    bus(1'b1, A_CTL, 32'h31);
    pulse(2);
    repeat (20) @(posedge i_sys_clk);
    step(2, 60, 6'h00, 10);
    step(2, 60, 6'h00, 6);
    bus(1'b0, A_STAT, 32'h0);
    check("accum", {28'h0, rd[S_ACC +: 4]}, 32'h9);
  endtask
  task automatic t_buffer;
    bus(1'b1, A_RISE, 32'h2);
    bus(1'b0, A_RISE, 32'h0);
    check("rise shadow", rd, 32'h2);
    step(2, 60, 6'h00, 10);
    step(2, 60, 6'h00, 6);
    bus(1'b1, A_CTL, 32'h131);
    bus(1'b0, A_STAT, 32'h0);
    check("load pending", {31'h0, rd[S_LOAD]}, 32'h1);
    step(2, 60, 6'h00, 10);
    bus(1'b0, A_STAT, 32'h0);
    check("load done", {31'h0, rd[S_LOAD]}, 32'h0);
    step(2, 60, 6'h00, 3);
  endtask
  task automatic t_overlap;
    bus(1'b1, A_RISE, 32'h28);
    bus(1'b1, A_CTL, 32'h131);
    step(2, 60, 6'h00, 10);
    step(2, 15, 6'h00, 15);
    step(2, 30, 6'h10, -1);
    bus(1'b1, cpd_pkg::OFS_FALL_TIME, 32'h28);
    bus(1'b1, A_CTL, 32'h131);
    step(2, 60, 6'h00, 41);
    step(2, 15, 6'h00, 15);
    step(2, 60, 6'h20, -1);
    step(2, 60, 6'h00, 41);
  endtask
  task automatic t_db_off;
    bus(1'b1, A_CTL, 32'h21);
    step(2, 2, 6'h20, -1);
    bus(1'b1, A_CTL, 32'h01);
    step(2, 2, 6'h10, -1);
  endtask
  task automatic t_three;
    bus(1'b1, A_STR, 32'h0);
    bus(1'b1, A_CTL, 32'h33);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, A_SEL, {26'h0, codes[i]});
      repeat (3) @(posedge i_sys_clk);
      rd = {26'h0, pair(codes[i])};
      check("pair", {26'h0, o_pwm}, rd);
    end
    bus(1'b1, A_SEL, 32'h1);
    bus(1'b1, A_STR, 32'h6);
    repeat (3) @(posedge i_sys_clk);
    step(1, 2, 6'h24, -1);
    step(0, 2, 6'h00, -1);
    bus(1'b1, A_STR, 32'h2);
    repeat (3) @(posedge i_sys_clk);
    check("low side static", {26'h0, o_pwm}, 32'h4);
    step(1, 2, 6'h24, -1);
    bus(1'b1, A_STR, 32'h4);
    step(0, 2, 6'h20, -1);
  endtask
  task automatic t_sync;
    bus(1'b1, A_STR, 32'h1);
    bus(1'b1, A_SEL, 32'h2);
    bus(1'b1, A_CTL, 32'h133);
    repeat (3) @(posedge i_sys_clk);
    check("held pair", {26'h0, o_pwm}, 32'h24);
    pulse(2);
    repeat (6) @(posedge i_sys_clk);
    check("loaded pair", {26'h0, o_pwm}, 32'h21);
    bus(1'b1, A_CTL, 32'h0);
    repeat (3) @(posedge i_sys_clk);
    check("disabled", {26'h0, o_pwm}, 32'h0);
    check("shoot through", {16'h0, shoot}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_deadband();
    t_buffer();
    t_overlap();
    t_db_off();
    t_three();
    t_sync();
    report_and_stop();
  end
  initial begin
    #60000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
